// ==== hdl/arb_pkg.sv ====
// constants shared by the bus arbitration logic and its input synchroniser
// assumes one 50 MHz system clock and active-low pins, except the rotating priority select and identifier pins
package arb_pkg;

   // clock figures
   localparam int          CLK_PERIOD_NS   = 20;            // system clock period
   localparam int          FLOAT_TIME_CLK  = 1;             // grant float time in input-clock cycles
   localparam int          FLOAT_CYCLES    = FLOAT_TIME_CLK; // one input clock is one system clock

   // processor count and identifier widths
   localparam int          NUM_PROCS       = 6;             // request lines on the shared bus
   localparam int          IDENT_W         = 3;             // identifier width
   localparam logic [2:0]  IDENT_NONE      = 3'h0;          // single processor, no request line

   // synchroniser bit positions
   localparam int          SYN_W           = 16;            // synchronised pin count
   localparam int          SYN_HREQ        = 0;             // host request
   localparam int          SYN_CS          = 1;             // host chip select
   localparam int          SYN_HGNT        = 2;             // host grant as seen on the wire
   localparam int          SYN_DMA_A       = 3;             // dma request a
   localparam int          SYN_DMA_B       = 4;             // dma request b
   localparam int          SYN_ROT         = 5;             // rotating priority select
   localparam int          SYN_PA          = 6;             // priority access line
   localparam int          SYN_PEER_LO     = 7;             // first peer request bit
   localparam int          SYN_IDENT_LO    = 13;            // first identifier bit

   // reset values of pins and state
   localparam logic        PIN_IDLE        = 1'h1;          // active-low pin at rest
   localparam logic        OE_OFF          = 1'h1;          // enable high leaves the pin undriven
   localparam logic [5:0]  PEER_OE_OFF     = 6'h3f;         // no request line driven
   localparam logic [5:0]  PEER_IDLE       = 6'h3f;         // request lines at rest

   // host grant handshake states
   typedef enum logic [2:0]
   {
      HS_IDLE  = 3'h1,
      HS_FLOAT = 3'h2,
      HS_GRANT = 3'h4
   } host_state_t;

endpackage : arb_pkg

// ==== hdl/pin_sync.sv ====
// two-flop synchroniser for the asynchronous arbitration pins
// assumes the inputs are pins that settle between clock edges
`timescale 1ns/10ps
module pin_sync
   import arb_pkg::*;
(
   // clock and reset
   input  wire logic             CLK_SYS_IN,
   input  wire logic             RSTN_IN,
   // pins in, synchronised copies out
   input  wire logic [SYN_W-1:0] PINS_IN,
   output logic      [SYN_W-1:0] PINS_OUT
);

   logic [SYN_W-1:0] meta_reg;   // first stage, read only by the second
   logic [SYN_W-1:0] stable_reg; // second stage

   // one pair of flops per pin; pins rest high
   genvar g;
   generate
      for (g = 0; g < SYN_W; g++)
      begin : g_bit
         always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
         begin
            if (!RSTN_IN)
            begin
               meta_reg[g]   <= 1'h1;
               stable_reg[g] <= 1'h1;
            end
            else
            begin
               meta_reg[g]   <= PINS_IN[g];
               stable_reg[g] <= meta_reg[g];
            end
         end
      end
   endgenerate

   assign PINS_OUT = stable_reg;

endmodule : pin_sync

// ==== hdl/bus_arbiter.sv ====
// external bus ownership: host grant, host wait line, dma grants, peer arbitration
// assumes identical peers on the same clock and the wire resolved outside from the enables
//
// Behaviour
// (RQ1) grant the host when it requests
// (RQ2) hold grant low until request withdrawn
// (RQ3) only bus master drives host grant
// (RQ4) grant floats one clock before driven
// (RQ5) host selects us for asynchronous transfers
// (RQ6) pull acknowledge low for wait states
// (RQ7) peripherals request dma on two lines
// (RQ8) dma grant precedes transfer by one cycle
// (RQ9) dma grants driven by master only
// (RQ10) identifier picks own request line
// (RQ11) identifier fixed or changed in reset
// (RQ12) drive own line, watch all others
// (RQ13) unused request lines held high externally
// (RQ14) select high rotates, low fixes priority
// (RQ15) priority select equal on all processors
// (RQ16) priority access suspends master background dma
// (RQ17) priority access line common to all
// (RQ18) host requests bus with active-low line
// (RQ19) host request beats all peer requests
// (RQ20) all decisions on clock edges, reset idle
// (RQ21) fixed lowest wins; rotating demotes last master
`timescale 1ns/10ps
module bus_arbiter
   import arb_pkg::*;
(
   // clock and reset
   input  wire logic       CLK_SYS_IN,
   input  wire logic       RSTN_IN,
   // host handshake pins
   input  wire logic       HOST_REQUEST_N_IN,
   input  wire logic       HOST_SELECT_N_IN,
   input  wire logic       HOST_GRANT_N_IN,
   output logic            HOST_GRANT_N_OUT,
   output logic            HOST_GRANT_N_OE_N_OUT,
   output logic            HOST_ASYNC_ACK_OUT,
   output logic            HOST_ASYNC_ACK_OE_N_OUT,
   // external dma pins
   input  wire logic       EXT_DMA_REQ_A_N_IN,
   input  wire logic       EXT_DMA_REQ_B_N_IN,
   output logic            EXT_DMA_GNT_A_N_OUT,
   output logic            EXT_DMA_GNT_A_N_OE_N_OUT,
   output logic            EXT_DMA_GNT_B_N_OUT,
   output logic            EXT_DMA_GNT_B_N_OE_N_OUT,
   // multiprocessor pins
   input  wire logic [2:0] PROC_IDENT_IN,
   input  wire logic [5:0] PEER_BUS_REQ_N_IN,
   output logic      [5:0] PEER_BUS_REQ_N_OUT,
   output logic      [5:0] PEER_BUS_REQ_N_OE_N_OUT,
   input  wire logic       ROTATE_PRIO_SEL_IN,
   input  wire logic       PRIO_ACCESS_N_IN,
   output logic            PRIO_ACCESS_N_OUT,
   output logic            PRIO_ACCESS_N_OE_N_OUT,
   // core side
   input  wire logic       BUS_NEED_IN,
   input  wire logic       PRIO_NEED_IN,
   input  wire logic       HOST_ACCESS_DONE_IN,
   input  wire logic       DMA_READY_IN,
   output logic            BUS_MASTER_OUT,
   output logic            HOST_OWNS_OUT,
   output logic            DMA_SUSPEND_OUT,
   output logic      [1:0] DMA_START_OUT
);

   // synchronised pins
   logic [SYN_W-1:0] pins;         // raw pins gathered
   logic [SYN_W-1:0] syn;          // their synchronised copies
   logic             hreq;         // host request active
   logic             hsel;         // chip select active
   logic             hgnt_seen;    // grant low on the wire
   logic             dreq_a;       // dma request a active
   logic             dreq_b;       // dma request b active
   logic             rot;          // rotating priority chosen
   logic             pa_seen;      // priority access low on the wire
   logic [5:0]       peer_req;     // active request lines
   logic [2:0]       ident;        // identifier as sampled

   // state
   host_state_t      hs_reg;       // host handshake state
   host_state_t      hs_next;
   logic [2:0]       master_reg;   // current master, 1..6, 0 none
   logic [2:0]       master_next;
   logic [2:0]       last_reg;     // previous master for rotation
   logic [2:0]       ident_reg;    // identifier caught after reset
   logic             is_master;    // this processor owns the bus
   logic             host_hold;    // host owns or is being granted the bus
   logic             arb_free;     // bus free for a new winner
   logic [5:0]       own_onehot;   // own request line
   logic             pa_other;     // someone else asserts priority access
   logic [2:0]       winner;       // candidate master

   // output registers
   logic             hgnt_reg;
   logic             hgnt_oe_reg;
   logic             ack_oe_reg;
   logic             gnt_a_reg;
   logic             gnt_b_reg;
   logic             gnt_oe_reg;
   logic [5:0]       peer_out_reg;
   logic [5:0]       peer_oe_reg;
   logic             pa_out_reg;
   logic             master_out_reg;
   logic             host_owns_reg;
   logic             suspend_reg;
   logic [1:0]       start_reg;

   // winner search, starting just past the start line
   function automatic logic [2:0] pick_winner(input logic [5:0] req,
                                              input logic [2:0] last,
                                              input logic       rotate);
      logic [2:0] win;
      int         k;
      int         idx;
      win = 3'h0;
      for (k = NUM_PROCS - 1; k >= 0; k--)
      begin
         idx = (rotate ? int'(last) + k : k) % NUM_PROCS;
         if (req[idx])
         begin
            win = 3'(idx + 1);
         end
      end
      return win;
   endfunction : pick_winner

   // every pin passes two flops first
   assign pins = {PROC_IDENT_IN, PEER_BUS_REQ_N_IN, PRIO_ACCESS_N_IN, ROTATE_PRIO_SEL_IN,
                  EXT_DMA_REQ_B_N_IN, EXT_DMA_REQ_A_N_IN, HOST_GRANT_N_IN, HOST_SELECT_N_IN,
                  HOST_REQUEST_N_IN};

   pin_sync u_sync
   (
      .CLK_SYS_IN (CLK_SYS_IN),
      .RSTN_IN    (RSTN_IN),
      .PINS_IN    (pins),
      .PINS_OUT   (syn)
   );

   // decoded synchronised pins, active high
   assign hreq      = !syn[SYN_HREQ];
   assign hsel      = !syn[SYN_CS];
   assign hgnt_seen = !syn[SYN_HGNT];
   assign dreq_a    = !syn[SYN_DMA_A];
   assign dreq_b    = !syn[SYN_DMA_B];
   assign rot       = syn[SYN_ROT];
   assign pa_seen   = !syn[SYN_PA];
   assign peer_req  = ~syn[SYN_PEER_LO +: NUM_PROCS];
   assign ident     = syn[SYN_IDENT_LO +: IDENT_W];

   // own line from the identifier; none for identifier zero
   assign own_onehot = (ident_reg == IDENT_NONE) ? 6'h00 : 6'(6'h01 << (ident_reg - 3'h1)); // see (RQ10)

   // single processor always masters; else the arbitrated index matches ours
   assign is_master = (ident_reg == IDENT_NONE) || (master_reg == ident_reg);

   // host request or a grant on the wire freezes peer arbitration
   assign host_hold = (hs_reg != HS_IDLE) || hgnt_seen; // see (RQ19)

   // another processor pulls priority access
   assign pa_other  = pa_seen && !PRIO_ACCESS_N_OE_N_OUT ? 1'h0 : pa_seen;

   // bus free when nobody owns it or the owner dropped its line
   assign arb_free  = !host_hold && ((master_reg == 3'h0) || !peer_req[master_reg - 3'h1]);
   // rotation starts just past the owner being replaced, else past the last owner
   assign winner    = pick_winner(peer_req, (master_reg != 3'h0) ? master_reg : last_reg, rot); // see (RQ14) (RQ21)

   // identifier is caught once per clock; stable outside reset by system wiring
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         ident_reg <= IDENT_NONE;
      end
      else
      begin
         ident_reg <= ident;
      end
   end

   // host handshake: float one clock, then grant until released
   always_comb
   begin
      hs_next = hs_reg;
      unique case (hs_reg)
         HS_IDLE:
         begin
            if (hreq)
            begin
               hs_next = HS_FLOAT; // see (RQ1) (RQ4)
            end
         end
         HS_FLOAT:
         begin
            hs_next = hreq ? HS_GRANT : HS_IDLE;
         end
         HS_GRANT:
         begin
            if (!hreq)
            begin
               hs_next = HS_IDLE; // see (RQ2)
            end
         end
      endcase
   end

   // arbitration result moves only while the bus is free
   always_comb
   begin
      master_next = master_reg;
      if (arb_free)
      begin
         master_next = winner; // see (RQ12) (RQ20)
      end
   end

   // state registers
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         hs_reg     <= HS_IDLE;
         master_reg <= 3'h0;
         last_reg   <= 3'h0;
      end
      else
      begin
         hs_reg     <= hs_next;
         master_reg <= master_next;
         // remember who held the bus for rotation
         if (arb_free && (master_reg != 3'h0))
         begin
            last_reg <= master_reg; // see (RQ21)
         end
      end
   end

   // host grant pin: master drives, float cycle and non-masters leave it open
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         hgnt_reg    <= PIN_IDLE;
         hgnt_oe_reg <= OE_OFF;
         host_owns_reg <= 1'h0;
      end
      else
      begin
         hgnt_reg      <= !(hs_next == HS_GRANT);
         hgnt_oe_reg   <= !(is_master && (hs_next != HS_FLOAT)); // see (RQ3) (RQ4)
         host_owns_reg <= (hs_next == HS_GRANT) || hgnt_seen;
      end
   end

   // open-drain wait line during an asynchronous host access
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         ack_oe_reg <= OE_OFF;
      end
      else
      begin
         ack_oe_reg <= !(hsel && hreq && !HOST_ACCESS_DONE_IN); // see (RQ6)
      end
   end

   // dma grants: one-cycle pulse, start follows; a before b
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         gnt_a_reg   <= PIN_IDLE;
         gnt_b_reg   <= PIN_IDLE;
         gnt_oe_reg  <= OE_OFF;
         start_reg   <= 2'h0;
         suspend_reg <= 1'h0;
      end
      else
      begin
         gnt_oe_reg  <= !is_master; // see (RQ9)
         suspend_reg <= is_master && pa_other; // see (RQ16)
         start_reg   <= {!gnt_b_reg, !gnt_a_reg}; // see (RQ8)
         gnt_a_reg   <= PIN_IDLE;
         gnt_b_reg   <= PIN_IDLE;
         // no grant back to back, none under host or priority access
         if (is_master && !host_hold && !pa_other && DMA_READY_IN && gnt_a_reg && gnt_b_reg)
         begin
            if (dreq_a)
            begin
               gnt_a_reg <= 1'h0; // see (RQ8)
            end
            else if (dreq_b)
            begin
               gnt_b_reg <= 1'h0;
            end
         end
      end
   end

   // own request line and priority access drive
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         peer_out_reg   <= PEER_IDLE;
         peer_oe_reg    <= PEER_OE_OFF;
         pa_out_reg     <= PIN_IDLE;
         master_out_reg <= 1'h0;
      end
      else
      begin
         peer_oe_reg  <= ~own_onehot; // see (RQ12)
         // master yields to a priority access from a slave
         peer_out_reg <= (BUS_NEED_IN || PRIO_NEED_IN) && !(is_master && pa_other)
                         ? ~own_onehot : PEER_IDLE; // see (RQ16)
         pa_out_reg   <= !(PRIO_NEED_IN && !is_master);
         master_out_reg <= is_master && !host_hold; // see (RQ19)
      end
   end

   // ports straight from flops; acknowledge and priority access values tied low
   assign HOST_GRANT_N_OUT         = hgnt_reg;
   assign HOST_GRANT_N_OE_N_OUT    = hgnt_oe_reg;
   assign HOST_ASYNC_ACK_OUT       = 1'h0;
   assign HOST_ASYNC_ACK_OE_N_OUT  = ack_oe_reg;
   assign EXT_DMA_GNT_A_N_OUT      = gnt_a_reg;
   assign EXT_DMA_GNT_B_N_OUT      = gnt_b_reg;
   assign EXT_DMA_GNT_A_N_OE_N_OUT = gnt_oe_reg;
   assign EXT_DMA_GNT_B_N_OE_N_OUT = gnt_oe_reg;
   assign PEER_BUS_REQ_N_OUT       = peer_out_reg;
   assign PEER_BUS_REQ_N_OE_N_OUT  = peer_oe_reg;
   assign PRIO_ACCESS_N_OUT        = 1'h0;
   assign PRIO_ACCESS_N_OE_N_OUT   = pa_out_reg;
   assign BUS_MASTER_OUT           = master_out_reg;
   assign HOST_OWNS_OUT            = host_owns_reg;
   assign DMA_SUSPEND_OUT          = suspend_reg;
   assign DMA_START_OUT            = start_reg;

   // checks
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RSTN_IN);

   // float then drive low
   sequence s_float_then_grant;
      HOST_GRANT_N_OE_N_OUT ##1 (!hreq || (!HOST_GRANT_N_OE_N_OUT && !HOST_GRANT_N_OUT));
   endsequence

   property p_host_float;
      (hs_reg == HS_IDLE) && hreq && is_master |=> s_float_then_grant;
   endproperty
   a_host_float: assert property (p_host_float) else $error("host grant float step wrong"); // see (RQ4)

   property p_grant_after_float;
      (hs_reg == HS_FLOAT) && hreq |=> (hs_reg == HS_GRANT) && !HOST_GRANT_N_OUT;
   endproperty
   a_grant_after_float: assert property (p_grant_after_float) else $error("host not granted"); // see (RQ1)

   property p_grant_held;
      (hs_reg == HS_GRANT) && hreq |=> !HOST_GRANT_N_OUT;
   endproperty
   a_grant_held: assert property (p_grant_held) else $error("host grant dropped early"); // see (RQ2)

   property p_nonmaster_quiet;
      !$past(is_master) |-> HOST_GRANT_N_OE_N_OUT && EXT_DMA_GNT_A_N_OE_N_OUT && EXT_DMA_GNT_B_N_OE_N_OUT;
   endproperty
   a_nonmaster_quiet: assert property (p_nonmaster_quiet) else $error("non-master drives grant"); // see (RQ3) (RQ9)

   property p_wait_state;
      hsel && hreq && !HOST_ACCESS_DONE_IN |=> !HOST_ASYNC_ACK_OE_N_OUT;
   endproperty
   a_wait_state: assert property (p_wait_state) else $error("wait line not pulled"); // see (RQ6)

   property p_dma_start;
      !EXT_DMA_GNT_A_N_OUT |=> DMA_START_OUT[0] && EXT_DMA_GNT_A_N_OUT;
   endproperty
   a_dma_start: assert property (p_dma_start) else $error("dma start not after grant"); // see (RQ8)

   property p_own_line;
      1'h1 |=> PEER_BUS_REQ_N_OE_N_OUT == ~$past(own_onehot);
   endproperty
   a_own_line: assert property (p_own_line) else $error("wrong request line driven"); // see (RQ10) (RQ12)

   property p_fixed_lowest;
      arb_free && !rot |=> master_reg == pick_winner($past(peer_req), 3'h0, 1'h0);
   endproperty
   a_fixed_lowest: assert property (p_fixed_lowest) else $error("fixed priority winner wrong"); // see (RQ21)

   property p_pa_suspend;
      is_master && pa_other |=> DMA_SUSPEND_OUT && EXT_DMA_GNT_A_N_OUT && EXT_DMA_GNT_B_N_OUT;
   endproperty
   a_pa_suspend: assert property (p_pa_suspend) else $error("dma not suspended"); // see (RQ16)

   property p_host_wins;
      host_hold |=> !BUS_MASTER_OUT;
   endproperty
   a_host_wins: assert property (p_host_wins) else $error("peer master during host hold"); // see (RQ19)

endmodule : bus_arbiter

// ==== dv/far_side_model.sv ====
// far side of the arbiter: host, peer processors and dma devices
// assumes the bench sets the intent inputs at the falling clock edge
`timescale 1ns/10ps
module far_side_model
(
   // intent from the bench
   input  wire logic       host_req_in,
   input  wire logic       host_sel_in,
   input  wire logic       dma_a_in,
   input  wire logic       dma_b_in,
   input  wire logic [5:0] peer_want_in,
   input  wire logic       peer_pa_in,
   // what the design drives, with enables
   input  wire logic       gnt_in,
   input  wire logic       gnt_oe_n_in,
   input  wire logic [5:0] req_in,
   input  wire logic [5:0] req_oe_n_in,
   input  wire logic       pa_oe_n_in,
   // resolved wires
   output logic            host_req_n_out,
   output logic            host_sel_n_out,
   output logic            dma_a_n_out,
   output logic            dma_b_n_out,
   output logic            gnt_n_out,
   output logic      [5:0] peer_n_out,
   output logic            pa_n_out
);
   // host asks for the bus with an active-low level
   assign host_req_n_out = ~host_req_in;
   // host selects us for asynchronous transfers
   assign host_sel_n_out = ~host_sel_in;
   // peripherals ask for channel 11 and channel 12
   assign dma_a_n_out    = ~dma_a_in;
   assign dma_b_n_out    = ~dma_b_in;
   // grant wire pulled up while floating
   assign gnt_n_out      = gnt_oe_n_in ? 1'h1 : gnt_in;
   // idle peer lines pulled high, own line left to the design
   assign peer_n_out     = (req_oe_n_in & ~peer_want_in) | (~req_oe_n_in & req_in);
   // one shared priority access line, pulled up
   assign pa_n_out       = pa_oe_n_in & ~peer_pa_in;
endmodule : far_side_model

// ==== dv/multiproc_bus_arbitration_bench.sv ====
// self-checking bench for the bus arbiter with its far-side model
// assumes single-clock design, inputs changed at the falling edge
`timescale 1ns/10ps
module multiproc_bus_arbitration_bench
   import arb_pkg::*;
;
   localparam int LIMIT = 4000;        // cycle ceiling for a hang
   logic       clk = 1'h0;             // system clock
   logic       rstn = 1'h0;            // reset, active low
   logic       h_req = 0, h_sel = 0;   // host intent
   logic       dma_a = 0, dma_b = 0;   // dma device intent
   logic       peer_pa = 0;            // other processor priority access
   logic [5:0] peer_want = 6'h00;      // peer lines asking
   logic [2:0] ident = 3'h0;           // identifier pins
   logic       rot = 0, bus_need = 0;  // priority select, core need
   logic       prio_need = 0, done = 0, dma_rdy = 1;
   logic       hreq_n, hsel_n, hgnt_n, da_n, db_n, pa_n;   // wires
   logic [5:0] peer_n, req, req_oe_n;
   logic       gnt, gnt_oe_n, ack_oe_n, ga, ga_oe_n, gb, gb_oe_n, pa_oe_n;
   logic       master, suspend, owns, ack, pa_v;
   logic [1:0] start;
   int         mismatches = 0;
   int         compares = 0;
   int         cycles = 0;
   int         seed = 48236;
   int         dma_q[$];               // expected dma starts

   // clock
   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   bus_arbiter uut
   (
      .CLK_SYS_IN(clk), .RSTN_IN(rstn),
      .HOST_REQUEST_N_IN(hreq_n), .HOST_SELECT_N_IN(hsel_n), .HOST_GRANT_N_IN(hgnt_n),
      .HOST_GRANT_N_OUT(gnt), .HOST_GRANT_N_OE_N_OUT(gnt_oe_n),
      .HOST_ASYNC_ACK_OUT(ack), .HOST_ASYNC_ACK_OE_N_OUT(ack_oe_n),
      .EXT_DMA_REQ_A_N_IN(da_n), .EXT_DMA_REQ_B_N_IN(db_n),
      .EXT_DMA_GNT_A_N_OUT(ga), .EXT_DMA_GNT_A_N_OE_N_OUT(ga_oe_n),
      .EXT_DMA_GNT_B_N_OUT(gb), .EXT_DMA_GNT_B_N_OE_N_OUT(gb_oe_n),
      .PROC_IDENT_IN(ident), .PEER_BUS_REQ_N_IN(peer_n),
      .PEER_BUS_REQ_N_OUT(req), .PEER_BUS_REQ_N_OE_N_OUT(req_oe_n),
      .ROTATE_PRIO_SEL_IN(rot), .PRIO_ACCESS_N_IN(pa_n),
      .PRIO_ACCESS_N_OUT(pa_v), .PRIO_ACCESS_N_OE_N_OUT(pa_oe_n),
      .BUS_NEED_IN(bus_need), .PRIO_NEED_IN(prio_need),
      .HOST_ACCESS_DONE_IN(done), .DMA_READY_IN(dma_rdy),
      .BUS_MASTER_OUT(master), .HOST_OWNS_OUT(owns), .DMA_SUSPEND_OUT(suspend),
      .DMA_START_OUT(start)
   );

   far_side_model far
   (
      .host_req_in(h_req), .host_sel_in(h_sel), .dma_a_in(dma_a), .dma_b_in(dma_b),
      .peer_want_in(peer_want), .peer_pa_in(peer_pa),
      .gnt_in(gnt), .gnt_oe_n_in(gnt_oe_n), .req_in(req), .req_oe_n_in(req_oe_n),
      .pa_oe_n_in(pa_oe_n),
      .host_req_n_out(hreq_n), .host_sel_n_out(hsel_n), .dma_a_n_out(da_n),
      .dma_b_n_out(db_n), .gnt_n_out(hgnt_n), .peer_n_out(peer_n), .pa_n_out(pa_n)
   );

   // verdict and end of run
   task automatic conclude;
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // one comparison
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (exp !== got)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // reference arbitration: bit index of the winner
   function automatic int winner(input logic [5:0] m, input int last, input logic r);
      int idx;
      for (int i = 0; i < 6; i++)
      begin
         idx = r ? (last + 1 + i) % 6 : i;
         if (m[idx])
            return idx;
      end
      return -1;
   endfunction : winner

   // reset with a new identifier and priority select
   task automatic do_reset(input logic [2:0] id, input logic r);
      rstn = 1'h0;
      ident = id;
      rot = r;
      {h_req, h_sel, dma_a, dma_b, peer_pa, bus_need, prio_need, done} = 8'h00;
      peer_want = 6'h00;
      repeat (2) @(negedge clk);
      check("reset enables", 8'hf8, {gnt_oe_n, ack_oe_n, ga_oe_n, gb_oe_n, pa_oe_n, master, suspend, |start});
      check("reset line enables", 8'h3f, {pa_v, ack, req_oe_n});
      rstn = 1'h1;
      repeat (4) @(negedge clk);
   endtask : do_reset

   // host grant, float cycle, hold, wait line, release
   task automatic host_cycle;
      int fl;
      int hold;
      fl = 0;
      hold = 4 + (($random(seed) & 32'h7fffffff) % 3);
      h_req = 1'h1;
      for (int k = 0; k < 10; k++)
      begin
         @(negedge clk);
         if (gnt_oe_n === 1'h0 && gnt === 1'h0)
            break;
         fl = (gnt_oe_n === 1'h1) ? fl + 1 : 0;
      end
      check("host grant", 8'h00, {7'h00, gnt});
      check("float cycles", 8'(FLOAT_CYCLES), 8'(fl));
      h_sel = 1'h1;
      for (int k = 1; k <= hold; k++)
      begin
         @(negedge clk);
         check("grant held", 8'h00, {7'h00, gnt});
         check("host owns bus", 8'h01, {7'h00, owns});
         if (k >= 3)
            check("wait line", 8'h00, {7'h00, ack_oe_n});
      end
      done = 1'h1;
      repeat (2) @(negedge clk);
      check("wait line released", 8'h01, {7'h00, ack_oe_n});
      {h_req, h_sel, done} = 3'h0;
      for (int k = 0; k < 6 && gnt !== 1'h1; k++)
         @(negedge clk);
      check("grant released", 8'h01, {7'h00, gnt});
   endtask : host_cycle

   // one dma request answered by a one-cycle grant then a start
   task automatic dma_cycle(input int ch);
      dma_q.push_back(ch);
      if (ch == 0) dma_a = 1'h1; else dma_b = 1'h1;
      for (int k = 0; k < 8 && {ga, gb} === 2'h3; k++)
         @(negedge clk);
      check("dma grant", 8'(2'h3 ^ (2'h1 << ch)), {6'h00, gb, ga});
      {dma_a, dma_b} = 2'h0;
      @(negedge clk);
      check("dma start", 8'(2'h1 << dma_q.pop_front()), {6'h00, start});
      check("dma grant pulse", 8'h03, {6'h00, ga, gb});
      repeat (4) @(negedge clk);
   endtask : dma_cycle

   // peer arbitration under fixed or rotating priority
   task automatic arb_run(input logic r);
      logic exp;
      do_reset(3'h1, r);
      peer_want = 6'h02;
      repeat (6) @(negedge clk);
      bus_need = 1'h1;
      peer_want = 6'h06;
      repeat (6) @(negedge clk);
      check("own line enable", 8'h3e, {2'h0, req_oe_n});
      check("own line value", 8'h00, {7'h00, req[0]});
      check("slave floats grants", 8'h07, {5'h00, gnt_oe_n, ga_oe_n, gb_oe_n});
      check("master while peer holds", 8'h00, {7'h00, master});
      peer_want = 6'h04;
      repeat (8) @(negedge clk);
      exp = (winner(6'h05, 1, r) == 0);
      check("arbitration winner", 8'(exp), {7'h00, master});
      check("master grant drive", {5'h00, {3{~exp}}}, {5'h00, gnt_oe_n, ga_oe_n, gb_oe_n});
      if (!exp)
      begin
         prio_need = 1'h1;
         repeat (4) @(negedge clk);
         check("priority access drive", 8'h00, {7'h00, pa_oe_n});
         prio_need = 1'h0;
      end
   endtask : arb_run

   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         conclude();
      end
   end

   // main sequence
   initial
   begin
      do_reset(3'h0, 1'h0);
      host_cycle();
      for (int n = 0; n < 4; n++)
         dma_cycle(n < 2 ? n : $random(seed) & 1);
      peer_pa = 1'h1;
      dma_a = 1'h1;
      for (int k = 0; k < 6; k++)
      begin
         @(negedge clk);
         if (k >= 3)
            check("suspend on priority access", 8'h03, {6'h00, suspend, ga});
      end
      peer_pa = 1'h0;
      dma_a = 1'h0;
      repeat (6) @(negedge clk);
      arb_run(1'h0);
      arb_run(1'h1);
      conclude();
   end
endmodule : multiproc_bus_arbitration_bench
